// ---- verilog/ctod_pkg.sv ----
// Purpose: Shared constants for the clock and tone output divider
// Assumes: Byte-wide register port, 16-bit addresses
// Notes:   Offsets, field positions and reset values live here only

package ctod_pkg;

  localparam int unsigned ADDR_W = 16;  // Register address width
  localparam int unsigned DATA_W = 8;   // Register data width
  localparam int unsigned CNT_W  = 13;  // Divider counter width

  // Register offsets
  localparam logic [ADDR_W-1:0] PORT14_DIRECTION_ADDR    = 16'hff2e;
  localparam logic [ADDR_W-1:0] OUTPUT_CLOCK_SELECT_ADDR = 16'hff40;

  // Reset values
  localparam logic [DATA_W-1:0] OUTPUT_CLOCK_SELECT_RST = 8'h00;
  localparam logic [DATA_W-1:0] PORT14_DIRECTION_RST    = 8'hff;
  localparam logic [DATA_W-1:0] DIR_FIXED_ONES          = 8'hfc;  // Bits 7..2 read as one

  // Field positions in output_clock_select
  localparam int unsigned TONE_ENABLE_BIT    = 7;
  localparam int unsigned TONE_RATE_LSB      = 5;
  localparam int unsigned CLOCK_OUT_EN_BIT   = 4;
  localparam int unsigned CLOCK_RATE_LSB     = 0;

  // Field positions in port14_direction
  localparam int unsigned CLOCK_PIN_DIR_BIT  = 0;
  localparam int unsigned TONE_PIN_DIR_BIT   = 1;

  // Division settings
  localparam int unsigned TONE_HALF_EXP_BASE = 9;      // Divide by 2^10 means 2^9 per half
  localparam logic [3:0]  CLOCK_CODE_SUB     = 4'h8;   // Subsystem clock selection
  localparam logic [3:0]  CLOCK_CODE_MAX_DIV = 4'h7;   // Divide by 128

endpackage

// ---- verilog/ctod_divider.sv ----
// Purpose: One glitch-free divided square wave with enable
// Assumes: ext_tick_in is already synchronous to clk_in
// Notes:   Wave starts with a full low phase and stops after a full high phase

`timescale 1ns/1ps

module ctod_divider #(
  parameter int unsigned CNT_W = 13             // Half-period counter width
) (
  input  wire logic             clk_in,         // Peripheral clock
  input  wire logic             resetn_in,      // Asynchronous reset, active low
  input  wire logic             enable_in,      // Output enable from software
  input  wire logic             use_ext_in,     // Take ticks from ext_tick_in
  input  wire logic             ext_tick_in,    // External edge pulse
  input  wire logic             block_in,       // Suppress all ticks
  input  wire logic [CNT_W-1:0] half_m1_in,     // Half period minus one
  output logic                  wave_out        // Divided wave
);

  logic [CNT_W-1:0] cnt_q;    // Half-period counter
  logic             run_q;    // Wave is active
  logic             out_q;    // Wave level
  logic             tick_w;   // Half-period boundary
  logic [CNT_W-1:0] gap_q;    // Helper: cycles since last tick
  logic             seen_q;   // Helper: one tick already seen

  // Boundary from own counter or from the external edge
  assign tick_w = !block_in && (use_ext_in ? ext_tick_in : (cnt_q == half_m1_in));

  // Counter is held clear while stopped and disabled, so the divider does not run
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
    end else if ((!run_q && !enable_in) || tick_w) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Wave sequencer: toggles only at boundaries
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_q <= 1'b0;
      out_q <= 1'b0;
    end else if (tick_w) begin
      if (!run_q) begin
        // First boundary opens a full low phase
        run_q <= enable_in;
      end else if (out_q) begin
        // High phase completes, then maybe stop
        out_q <= 1'b0;
        run_q <= enable_in;
      end else if (enable_in) begin
        // Low phase completes, rise
        out_q <= 1'b1;
      end else begin
        // Disabled at end of low phase
        run_q <= 1'b0;
      end
    end
  end

  assign wave_out = out_q;

  // Helper: spacing of internal ticks
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= tick_w ? '0 : gap_q + 1'b1;
      seen_q <= (tick_w || seen_q) && (run_q || enable_in) && !use_ext_in && !block_in;
    end
  end

  a_half_period: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tick_w && seen_q && !use_ext_in && $stable(half_m1_in) |-> gap_q == half_m1_in)
    else $error("Divider half period differs from setting");

  // A rise needs a low phase opened by an earlier boundary; holds for one-cycle halves too
  a_start_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(out_q) |-> $past(run_q) && $past(tick_w))
    else $error("Wave did not start with a low phase");

  a_fall_on_tick: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(out_q) |-> $past(tick_w) && $past(run_q))
    else $error("High phase cut short");

  a_idle_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !run_q |-> !out_q)
    else $error("Wave high while stopped");

endmodule // ctod_divider

// ---- verilog/ctod_top.sv ----
// Purpose: Clock output and tone output controller with its two registers
// Assumes: Peripheral clock is ref_clk_in; subsystem clock arrives on a pin
// Notes:   Byte and single-bit register writes; pins drive latch OR wave
//
// Behaviour
// - Select register resets zero; byte and bit writes
// - Tone enable low stops divider, wave low; pin follows latch
// - Tone rate selects divide by 2^10..2^13
// - Clock enable low stops divider, wave low; pin follows latch
// - Clock rate: code zero /2, /2../128, subsystem, prohibited
// - No short pulses on enable or disable
// - Direction register resets ones; low bits select output

`timescale 1ns/1ps

module ctod_top
  import ctod_pkg::*;
#(
  parameter int unsigned DIV_W = ctod_pkg::CNT_W  // Divider counter width
) (
  input  wire logic                        ref_clk_in,            // Peripheral clock
  input  wire logic                        resetn_in,             // Async reset, active low
  input  wire logic [ctod_pkg::ADDR_W-1:0] addr_in,               // Register address
  input  wire logic                        wr_en_in,              // Byte write strobe
  input  wire logic [ctod_pkg::DATA_W-1:0] wr_data_in,            // Byte write data
  input  wire logic                        bit_wr_en_in,          // Single-bit write strobe
  input  wire logic [2:0]                  bit_sel_in,            // Bit number for bit write
  input  wire logic                        bit_val_in,            // Bit value for bit write
  input  wire logic                        rd_en_in,              // Read strobe
  input  wire logic [1:0]                  port14_latch_in,       // Port output latch bits
  input  wire logic                        sub_clk_in,            // Subsystem clock pin
  output logic      [ctod_pkg::DATA_W-1:0] rd_data_out,           // Read data, one cycle later
  output logic                             divided_clock_pin_out, // Clock pin level
  output logic                             divided_clock_pin_oe_out, // Clock pin drive
  output logic                             tone_pin_out,          // Tone pin level
  output logic                             tone_pin_oe_out        // Tone pin drive
);

  import ctod_pkg::*;

  logic [DATA_W-1:0] output_clock_select_q;  // Select register
  logic [1:0]        port14_direction_q;     // Writable direction bits
  logic [DATA_W-1:0] dir_view_w;             // Direction register as read
  logic [DATA_W-1:0] rd_data_q;              // Read data register
  logic              sub_s1_q;               // Subsystem clock sync, first stage
  logic              sub_s2_q;               // Subsystem clock sync, second stage
  logic              sub_s3_q;               // Delayed for edge detect
  logic              sub_tick_w;             // Subsystem clock edge
  logic              tone_enable_w;          // Tone enable field
  logic [1:0]        tone_rate_w;            // Tone rate field
  logic              clock_out_enable_w;     // Clock enable field
  logic [3:0]        clock_rate_w;           // Clock rate field
  logic [DIV_W-1:0]  tone_half_m1_w;         // Tone half period minus one
  logic [DIV_W-1:0]  clock_half_m1_w;        // Clock half period minus one
  logic              clock_use_sub_w;        // Subsystem clock selected
  logic              clock_bad_w;            // Prohibited clock code
  logic              tone_wave_w;            // Tone divider output
  logic              clock_wave_w;           // Clock divider output
  logic              sel_hit_w;              // Address hits select register
  logic              dir_hit_w;              // Address hits direction register
  logic              tone_q;                 // Tone pin level
  logic              tone_oe_q;              // Tone pin drive
  logic              clock_q;                // Clock pin level
  logic              clock_oe_q;             // Clock pin drive

  assign sel_hit_w = (addr_in == OUTPUT_CLOCK_SELECT_ADDR);
  assign dir_hit_w = (addr_in == PORT14_DIRECTION_ADDR);

  // Field views of the select register; direction register as read
  assign tone_enable_w      = output_clock_select_q[TONE_ENABLE_BIT];
  assign tone_rate_w        = output_clock_select_q[TONE_RATE_LSB +: 2];
  assign clock_out_enable_w = output_clock_select_q[CLOCK_OUT_EN_BIT];
  assign clock_rate_w       = output_clock_select_q[CLOCK_RATE_LSB +: 4];
  assign dir_view_w         = DIR_FIXED_ONES | {6'h00, port14_direction_q};

  // Select register: byte and single-bit writes
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      output_clock_select_q <= OUTPUT_CLOCK_SELECT_RST;
    end else if (wr_en_in && sel_hit_w) begin
      output_clock_select_q <= wr_data_in;
    end else if (bit_wr_en_in && sel_hit_w) begin
      output_clock_select_q[bit_sel_in] <= bit_val_in;
    end
  end

  // Direction register: only the two low bits are stored
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      port14_direction_q <= PORT14_DIRECTION_RST[1:0];
    end else if (wr_en_in && dir_hit_w) begin
      port14_direction_q <= wr_data_in[1:0];
    end else if (bit_wr_en_in && dir_hit_w && (bit_sel_in < 3'h2)) begin
      port14_direction_q[bit_sel_in[0]] <= bit_val_in;
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_q <= 8'h00;
    end else if (rd_en_in) begin
      if (sel_hit_w) begin
        rd_data_q <= output_clock_select_q;
      end else if (dir_hit_w) begin
        rd_data_q <= dir_view_w;
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end

  // Subsystem clock pin: two-stage sync, then edge detect on stage two
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end else begin
      sub_s1_q <= sub_clk_in;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end

  assign sub_tick_w = sub_s2_q ^ sub_s3_q;

  // Tone half period: divide by 2^(10+rate) gives 2^(9+rate) cycles per half
  assign tone_half_m1_w = DIV_W'((32'h1 << (TONE_HALF_EXP_BASE + 32'(tone_rate_w))) - 1);

  // Clock half period: code n of 1..7 divides by 2^n; code zero toggles each cycle
  always_comb begin
    clock_half_m1_w = '0;
    clock_use_sub_w = 1'b0;
    clock_bad_w     = 1'b0;
    if (clock_rate_w == CLOCK_CODE_SUB) begin
      clock_use_sub_w = 1'b1;
    end else if (clock_rate_w > CLOCK_CODE_MAX_DIV) begin
      clock_bad_w     = 1'b1;
    end else if (clock_rate_w != 4'h0) begin
      clock_half_m1_w = DIV_W'((32'h1 << (32'(clock_rate_w) - 1)) - 1);
    end
  end

  // Tone divider
  ctod_divider #(
    .CNT_W      (DIV_W)
  ) u_tone_div (
    .clk_in     (ref_clk_in),
    .resetn_in  (resetn_in),
    .enable_in  (tone_enable_w),
    .use_ext_in (1'b0),
    .ext_tick_in(1'b0),
    .block_in   (1'b0),
    .half_m1_in (tone_half_m1_w),
    .wave_out   (tone_wave_w)
  );

  // Clock output divider
  ctod_divider #(
    .CNT_W      (DIV_W)
  ) u_clock_div (
    .clk_in     (ref_clk_in),
    .resetn_in  (resetn_in),
    .enable_in  (clock_out_enable_w),
    .use_ext_in (clock_use_sub_w),
    .ext_tick_in(sub_tick_w),
    .block_in   (clock_bad_w),
    .half_m1_in (clock_half_m1_w),
    .wave_out   (clock_wave_w)
  );

  // Pin drivers: wave OR port latch, buffer on when direction bit is zero
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tone_q     <= 1'b0;
      tone_oe_q  <= 1'b0;
      clock_q    <= 1'b0;
      clock_oe_q <= 1'b0;
    end else begin
      tone_q     <= tone_wave_w | port14_latch_in[TONE_PIN_DIR_BIT];
      clock_q    <= clock_wave_w | port14_latch_in[CLOCK_PIN_DIR_BIT];
      tone_oe_q  <= !port14_direction_q[TONE_PIN_DIR_BIT];
      clock_oe_q <= !port14_direction_q[CLOCK_PIN_DIR_BIT];
    end
  end

  assign rd_data_out              = rd_data_q;
  assign tone_pin_out             = tone_q;
  assign tone_pin_oe_out          = tone_oe_q;
  assign divided_clock_pin_out    = clock_q;
  assign divided_clock_pin_oe_out = clock_oe_q;

  a_byte_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    wr_en_in && sel_hit_w |=> output_clock_select_q == $past(wr_data_in))
    else $error("Select register byte write lost");

  a_bit_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !wr_en_in && bit_wr_en_in && sel_hit_w
      |=> output_clock_select_q[$past(bit_sel_in)] == $past(bit_val_in))
    else $error("Select register bit write lost");

  a_dir_read: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    rd_en_in && dir_hit_w |=> rd_data_out[7:2] == 6'h3f)
    else $error("Direction upper bits not read as one");

  a_pin_enable: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    port14_direction_q[TONE_PIN_DIR_BIT] |=> !tone_pin_oe_out)
    else $error("Tone pin driven while set as input");

  a_tone_off_low: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !tone_enable_w && !tone_wave_w && !port14_latch_in[TONE_PIN_DIR_BIT]
      |=> !tone_wave_w && !tone_pin_out)
    else $error("Tone pin high while stopped");

  a_clock_bad_low: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clock_bad_w && !clock_wave_w |=> !clock_wave_w)
    else $error("Clock wave rose on prohibited code");

  a_tone_rate_map: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    tone_rate_w == 2'h3 |-> tone_half_m1_w == 13'h0fff)
    else $error("Tone slowest rate wrong");

  a_clock_div128: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    clock_rate_w == 4'h7 |-> clock_half_m1_w == 13'h003f && !clock_use_sub_w)
    else $error("Clock divide by 128 wrong");

endmodule // ctod_top

// ---- sim/ctod_pin_monitor.sv ----
// Purpose: Receiver model of a clock or tone pin; measures run lengths
// Assumes: The wire is pulled low while the pin does not drive it
// Notes:   Low runs count only between a fall and the next rise

`timescale 1ns/1ps

module ctod_pin_monitor (
  input  wire logic        clk_in,      // Sampling clock
  input  wire logic        clr_in,      // Clear statistics
  input  wire logic        pin_in,      // Pin level
  input  wire logic        oe_in,       // Pin drive enable
  output logic             line_out,    // Level seen on the wire
  output logic [15:0]      min_hi_out,  // Shortest high run
  output logic [15:0]      max_hi_out,  // Longest high run
  output logic [15:0]      min_lo_out,  // Shortest low run
  output logic [15:0]      max_lo_out,  // Longest low run
  output logic [15:0]      rises_out    // Rising edges seen
);
  logic [15:0] run_q;   // Length of the current run
  logic        prev_q;  // Level at the last edge
  logic        fell_q;  // A fall was seen since clear

  // Undriven wire sits at the pull-down level
  assign line_out = oe_in ? pin_in : 1'b0;

  // Measure runs; each edge closes the run before it
  always_ff @(posedge clk_in) begin
    prev_q <= line_out;
    run_q  <= (line_out != prev_q) ? 16'h0001 : run_q + 16'h0001;
    if (clr_in) begin
      fell_q     <= 1'b0;
      rises_out  <= 16'h0000;
      min_hi_out <= 16'hffff;
      max_hi_out <= 16'h0000;
      min_lo_out <= 16'hffff;
      max_lo_out <= 16'h0000;
    end else if (line_out && !prev_q) begin  // Rise closes a low run
      rises_out <= rises_out + 16'h0001;
      if (fell_q && run_q < min_lo_out) min_lo_out <= run_q;
      if (fell_q && run_q > max_lo_out) max_lo_out <= run_q;
    end else if (!line_out && prev_q) begin  // Fall closes a high run
      fell_q <= 1'b1;
      if (run_q < min_hi_out) min_hi_out <= run_q;
      if (run_q > max_hi_out) max_hi_out <= run_q;
    end
  end
endmodule // ctod_pin_monitor

// ---- sim/testbench.sv ----
// Purpose: Self-checking bench for the clock and tone output divider
// Assumes: One pin monitor, switched between the two pins
// Notes:   Bench clock stands in for a slower peripheral clock

`timescale 1ns/1ps

module testbench;
  import ctod_pkg::*;
  logic        clk, resetn, wr_en, bwr_en, bval, rd_en, sub_clk;
  logic        divided_clock_pin, pcl_oe, tone, tone_oe, sel_tone, clr, line;
  logic [15:0] addr, mn_hi, mx_hi, mn_lo, mx_lo, rises;
  logic [7:0]  wr_data, rd_data;
  logic [2:0]  bsel;
  logic [1:0]  latch;
  int          bad_count = 0;
  int          tests_run = 0;
  localparam logic [15:0] SEL = OUTPUT_CLOCK_SELECT_ADDR;
  localparam logic [15:0] DIR = PORT14_DIRECTION_ADDR;

  ctod_top uut (.ref_clk_in(clk), .resetn_in(resetn), .addr_in(addr), .wr_en_in(wr_en),
    .wr_data_in(wr_data), .bit_wr_en_in(bwr_en), .bit_sel_in(bsel), .bit_val_in(bval),
    .rd_en_in(rd_en), .port14_latch_in(latch), .sub_clk_in(sub_clk), .rd_data_out(rd_data),
    .divided_clock_pin_out(divided_clock_pin), .divided_clock_pin_oe_out(pcl_oe), .tone_pin_out(tone),
    .tone_pin_oe_out(tone_oe));

  ctod_pin_monitor mon (.clk_in(clk), .clr_in(clr), .pin_in(sel_tone ? tone : divided_clock_pin),
    .oe_in(sel_tone ? tone_oe : pcl_oe), .line_out(line), .min_hi_out(mn_hi),
    .max_hi_out(mx_hi), .min_lo_out(mn_lo), .max_lo_out(mx_lo), .rises_out(rises));

  // Peripheral clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Free-running subsystem clock, six peripheral cycles per half
  initial begin
    sub_clk = 1'b0;
    forever #48 sub_clk = ~sub_clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Byte write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // Single-bit write
  task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
    @(posedge clk);
    addr   <= a;
    bsel   <= b;
    bval   <= v;
    bwr_en <= 1'b1;
    @(posedge clk);
    bwr_en <= 1'b0;
  endtask

  // Read and compare; data lands one cycle after the read edge
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    #1;
    check(16'(rd_data), 16'(exp));
  endtask

  // Clear the monitor statistics
  task automatic pulse_clr();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  // Wait for a wire level, bounded
  task automatic wait_lvl(input logic lvl, input int lim, output int n);
    n = 0;
    #1;
    while (line !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(line), 16'(lvl));
  endtask

  // Program a rate, enable, take one period, disable during high
  task automatic run_out(input logic [7:0] sel, input logic [2:0] eb, input int half);
    int n;
    wr(SEL, sel);
    rd(SEL, sel);
    pulse_clr();
    bwr(SEL, eb, 1'b1);
    wait_lvl(1'b1, 3 * half + 16, n);
    check(16'(n >= half), 16'h0001);
    wait_lvl(1'b0, half + 4, n);
    wait_lvl(1'b1, half + 4, n);
    bwr(SEL, eb, 1'b0);
    repeat (2 * half + 8) @(posedge clk);
    #1;
    check(16'(line), 16'h0000);
    check(16'(rises >= 2), 16'h0001);
    check(mn_hi, 16'(half));
    check(mx_hi, 16'(half));
    check(mn_lo, 16'(half));
    check(mx_lo, 16'(half));
  endtask

  // Main sequence
  initial begin
    resetn   = 1'b0;
    addr     = 16'h0000;
    wr_en    = 1'b0;
    wr_data  = 8'h00;
    bwr_en   = 1'b0;
    bsel     = 3'h0;
    bval     = 1'b0;
    rd_en    = 1'b0;
    latch    = 2'h0;
    sel_tone = 1'b0;
    clr      = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(SEL, 8'h00);
    rd(DIR, 8'hff);
    check({14'h0, pcl_oe, tone_oe}, 16'h0000);
    wr(16'hff41, 8'h5a);
    rd(16'hff41, 8'h00);
    wr(DIR, 8'h00);
    rd(DIR, 8'hfc);
    bwr(DIR, 3'h7, 1'b0);
    rd(DIR, 8'hfc);
    bwr(DIR, 3'h0, 1'b1);
    rd(DIR, 8'hfd);
    check({14'h0, pcl_oe, tone_oe}, 16'h0001);
    bwr(DIR, 3'h0, 1'b0);
    latch <= 2'h3;
    repeat (4) @(posedge clk);
    #1;
    check({14'h0, divided_clock_pin, tone}, 16'h0003);
    @(posedge clk);
    latch <= 2'h0;
    repeat (100) @(posedge clk);
    #1;
    check({14'h0, divided_clock_pin, tone}, 16'h0000);
    sel_tone <= 1'b1;
    for (int r = 0; r < 4; r++) run_out(8'(r << 5), 3'h7, 512 << r);
    sel_tone <= 1'b0;
    // Fast codes stand for a slower peripheral clock on silicon
    for (int c = 0; c < 8; c++) run_out(8'(c), 3'h4, (c == 0) ? 1 : 1 << (c - 1));
    run_out(8'h08, 3'h4, 6);
    for (int c = 9; c < 16; c++) begin
      wr(SEL, 8'(c));
      pulse_clr();
      bwr(SEL, 3'h4, 1'b1);
      repeat (40) @(posedge clk);
      #1;
      check(rises, 16'h0000);
      bwr(SEL, 3'h4, 1'b0);
    end
    // Second reset in mid-run brings both registers back
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(SEL, 8'h00);
    rd(DIR, 8'hff);
    check({14'h0, pcl_oe, tone_oe}, 16'h0000);
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule // testbench
